// ===== rtl/pmme_pkg.sv
// Shared constants and types of the pipelined matrix multiply engine.
package pmme_pkg;

	// Address generator width and the word space it spans.
	localparam int unsigned ADDR_W     = 16;
	localparam int unsigned ADDR_SPACE = 65536;

	// Default operand width and accumulator width.
	localparam int unsigned DATA_W_DEF = 16;
	localparam int unsigned ACC_W_DEF  = 40;
	localparam int unsigned CNT_W_DEF  = 16;

	// Stages between the last issue and the last product write.
	localparam logic [2:0] PIPE_DEPTH  = 3'h4;

	// Reset value of pointers and displacements.
	localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;

	// Address generator operation.
	typedef enum logic [1:0] {
		PMME_OP_HOLD,
		PMME_OP_LOAD,
		PMME_OP_ADD
	} pmme_op_e;

	// Sequencer states.
	typedef enum logic [1:0] {
		PMME_ST_IDLE,
		PMME_ST_RUN,
		PMME_ST_DRAIN
	} pmme_state_e;

endpackage

// ===== rtl/pmme_agen_if.sv
// Link between the sequencer and one ALU address generator.
`timescale 1ns/1ps
`default_nettype none
interface pmme_agen_if;
	import pmme_pkg::*;

	pmme_op_e            op;
	logic [ADDR_W-1:0]   value;
	logic [ADDR_W-1:0]   addr;

	modport ctrl (output op, output value, input addr);
	modport alu  (input op, input value, output addr);
endinterface
`default_nettype wire

// ===== rtl/pmme_agen.sv
// ALU address generator: pointer plus displacement into an output register.
`timescale 1ns/1ps
`default_nettype none
module pmme_agen
(
	input  wire logic    clk,
	input  wire logic    rst,
	pmme_agen_if.alu     ag
);
	import pmme_pkg::*;

	logic [ADDR_W-1:0] addr_r;
	logic [ADDR_W-1:0] sum;

	////////////////////////////////////////////////////////////////////////
	// The ALU adds the registered displacement to the current pointer.
	always_comb
	begin
		sum = addr_r + ag.value;
	end

	// The output register is both the pointer and the memory address.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			addr_r <= ADDR_RST;
		else
		begin
			unique case (ag.op)
				PMME_OP_HOLD: addr_r <= addr_r;
				PMME_OP_LOAD: addr_r <= ag.value;
				PMME_OP_ADD:  addr_r <= sum;
			endcase
		end
	end

	assign ag.addr = addr_r;

	////////////////////////////////////////////////////////////////////////
	a_alu_sum_add: assert property (@(posedge clk) disable iff (rst)
		ag.op == PMME_OP_ADD |=> addr_r == $past(addr_r) + $past(ag.value))
		else $error("Address generator did not add the displacement.");

	a_alu_load_base: assert property (@(posedge clk) disable iff (rst)
		ag.op == PMME_OP_LOAD |=> addr_r == $past(ag.value))
		else $error("Address generator did not load the base pointer.");
endmodule
`default_nettype wire

// ===== rtl/pmme_engine.sv
// Top of the four-stage pipelined matrix multiply engine.
//
// Summary of operation
// - Walking the second matrix by column, its pointer steps by that matrix's column stride.
// - Every new address other than a loaded base or row/column start is the ALU sum of the current pointer and a displacement.
// - Each address generator is 16 bits wide, covering 64K words.
// - Addressing, memory read, multiply-accumulate and write all run concurrently each cycle.
// - Stage one adds registered inputs and holds the result in the address output register.
// - The two registered operands are multiplied and the product added into the accumulator.
// - A finished sum moves to a separate output register so the next sum can start.
// - Three banks let one entry of each operand be read and one product written per cycle.
// - Each bank has its own address generator, all working at once.
// - The product address appears in the same cycle as the product data.
// - With the pipeline full one unit operation completes every clock.
// - Three nested loops run over rows of the first, columns of the second, columns of the first.
// - Sequentially stored matrices are read row after row with a displacement of one.
// - Two interleaved matrices are each read with a displacement of two.
`timescale 1ns/1ps
`default_nettype none
module pmme_engine
#(
	parameter int unsigned DATA_W = pmme_pkg::DATA_W_DEF,
	parameter int unsigned ACC_W  = pmme_pkg::ACC_W_DEF,
	parameter int unsigned CNT_W  = pmme_pkg::CNT_W_DEF
)
(
	input  wire logic                       clk,
	input  wire logic                       rst,
	input  wire logic                       start,
	input  wire logic [CNT_W-1:0]           first_matrix_row_count,
	input  wire logic [CNT_W-1:0]           first_matrix_column_count,
	input  wire logic [CNT_W-1:0]           second_matrix_column_count,
	input  wire logic [pmme_pkg::ADDR_W-1:0] a_base,
	input  wire logic [pmme_pkg::ADDR_W-1:0] a_disp,
	input  wire logic [pmme_pkg::ADDR_W-1:0] a_row_disp,
	input  wire logic [pmme_pkg::ADDR_W-1:0] b_base,
	input  wire logic [pmme_pkg::ADDR_W-1:0] b_disp,
	input  wire logic [pmme_pkg::ADDR_W-1:0] b_col_disp,
	input  wire logic [pmme_pkg::ADDR_W-1:0] c_base,
	input  wire logic [pmme_pkg::ADDR_W-1:0] c_disp,
	input  wire logic [DATA_W-1:0]          rd_data_a,
	input  wire logic [DATA_W-1:0]          rd_data_b,
	output wire logic [pmme_pkg::ADDR_W-1:0] rd_addr_a,
	output wire logic [pmme_pkg::ADDR_W-1:0] rd_addr_b,
	output var  logic                       rd_en,
	output wire logic [pmme_pkg::ADDR_W-1:0] wr_addr_c,
	output var  logic [ACC_W-1:0]           wr_data_c,
	output var  logic                       wr_en,
	output var  logic                       busy,
	output var  logic                       done
);
	import pmme_pkg::*;

	// One generator per bank so all three addresses move in one cycle.
	pmme_agen_if ag_a ();
	pmme_agen_if ag_b ();
	pmme_agen_if ag_c ();

	pmme_agen u_agen_a (.clk(clk), .rst(rst), .ag(ag_a.alu));
	pmme_agen u_agen_b (.clk(clk), .rst(rst), .ag(ag_b.alu));
	pmme_agen u_agen_c (.clk(clk), .rst(rst), .ag(ag_c.alu));

	pmme_state_e         st_r;
	logic [CNT_W-1:0]    rows_r, cols_a_r, cols_b_r;
	logic [CNT_W-1:0]    i_r, k_r, j_r;
	logic [ADDR_W-1:0]   a_disp_r, a_row_disp_r, b_disp_r, b_col_disp_r;
	logic [ADDR_W-1:0]   b_base_r, c_base_r, c_disp_r;
	logic [ADDR_W-1:0]   row_a_r, col_b_r;
	logic [2:0]          drain_r;
	pmme_op_e            a_op_r, b_op_r, c_op_r;
	logic [ADDR_W-1:0]   a_val_r, b_val_r, c_val_r;
	logic                iv_r, ifirst_r, ilast_r;
	logic                v1_r, first1_r, last1_r;
	logic                v2_r, first2_r, last2_r;
	logic                c_first_r;
	logic [DATA_W-1:0]   op_a_r, op_b_r;
	logic [ACC_W-1:0]    acc_r;
	logic [ACC_W-1:0]    prod;
	logic [ACC_W-1:0]    acc_nxt;
	logic                j_last, k_last, i_last, zero_cnt;

	assign ag_a.op    = a_op_r;
	assign ag_a.value = a_val_r;
	assign ag_b.op    = b_op_r;
	assign ag_b.value = b_val_r;
	assign ag_c.op    = c_op_r;
	assign ag_c.value = c_val_r;
	assign rd_addr_a  = ag_a.addr;
	assign rd_addr_b  = ag_b.addr;
	assign wr_addr_c  = ag_c.addr;

	// Loop end tests, shared by the sequencer and the issue stage.
	assign j_last   = (j_r == cols_a_r - 16'h0001);
	assign k_last   = (k_r == cols_b_r - 16'h0001);
	assign i_last   = (i_r == rows_r - 16'h0001);
	assign zero_cnt = (first_matrix_row_count == '0) ||
		(first_matrix_column_count == '0) || (second_matrix_column_count == '0);

	////////////////////////////////////////////////////////////////////////
	// Loop sequencer: i over first rows, k over second columns, j inner.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			st_r    <= PMME_ST_IDLE;
			i_r     <= '0;
			k_r     <= '0;
			j_r     <= '0;
			drain_r <= 3'h0;
			done    <= 1'b0;
			busy    <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			unique case (st_r)
				PMME_ST_IDLE:
				begin
					i_r <= '0;
					k_r <= '0;
					j_r <= '0;
					// An empty matrix finishes at once instead of hanging.
					if (start && zero_cnt)
						done <= 1'b1;
					else if (start)
					begin
						st_r <= PMME_ST_RUN;
						busy <= 1'b1;
					end
				end
				PMME_ST_RUN:
				begin
					drain_r <= 3'h0;
					if (!j_last)
						j_r <= j_r + 16'h0001;
					else
					begin
						j_r <= '0;
						if (!k_last)
							k_r <= k_r + 16'h0001;
						else
						begin
							k_r <= '0;
							i_r <= i_r + 16'h0001;
							if (i_last)
								st_r <= PMME_ST_DRAIN;
						end
					end
				end
				PMME_ST_DRAIN:
				begin
					// Let the last entry flow out of all four stages.
					drain_r <= drain_r + 3'h1;
					if (drain_r == PIPE_DEPTH - 3'h1)
					begin
						st_r <= PMME_ST_IDLE;
						busy <= 1'b0;
						done <= 1'b1;
					end
				end
				default:
					st_r <= PMME_ST_IDLE;
			endcase
		end
	end

	// Controller-supplied pointers and displacements, held for the run.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rows_r       <= '0;
			cols_a_r     <= '0;
			cols_b_r     <= '0;
			a_disp_r     <= ADDR_RST;
			a_row_disp_r <= ADDR_RST;
			b_disp_r     <= ADDR_RST;
			b_col_disp_r <= ADDR_RST;
			b_base_r     <= ADDR_RST;
			c_base_r     <= ADDR_RST;
			c_disp_r     <= ADDR_RST;
		end
		else if (st_r == PMME_ST_IDLE && start)
		begin
			rows_r       <= first_matrix_row_count;
			cols_a_r     <= first_matrix_column_count;
			cols_b_r     <= second_matrix_column_count;
			a_disp_r     <= a_disp;
			a_row_disp_r <= a_row_disp;
			b_disp_r     <= b_disp;
			b_col_disp_r <= b_col_disp;
			b_base_r     <= b_base;
			c_base_r     <= c_base;
			c_disp_r     <= c_disp;
		end
	end

	// Start-of-row pointer of A and start-of-column pointer of B.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			row_a_r <= ADDR_RST;
			col_b_r <= ADDR_RST;
		end
		else if (st_r == PMME_ST_IDLE && start)
		begin
			row_a_r <= a_base;
			col_b_r <= b_base;
		end
		else if (st_r == PMME_ST_RUN && j_last)
		begin
			if (k_last)
			begin
				row_a_r <= row_a_r + a_row_disp_r;
				col_b_r <= b_base_r;
			end
			else
				col_b_r <= col_b_r + b_col_disp_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Issue stage: one A and one B operation per run cycle, no bubbles.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			a_op_r   <= PMME_OP_HOLD;
			b_op_r   <= PMME_OP_HOLD;
			a_val_r  <= ADDR_RST;
			b_val_r  <= ADDR_RST;
			iv_r     <= 1'b0;
			ifirst_r <= 1'b0;
			ilast_r  <= 1'b0;
		end
		else if (st_r == PMME_ST_RUN)
		begin
			iv_r     <= 1'b1;
			ifirst_r <= (j_r == '0);
			ilast_r  <= j_last;
			a_op_r   <= (j_r == '0) ? PMME_OP_LOAD : PMME_OP_ADD;
			a_val_r  <= (j_r == '0) ? row_a_r : a_disp_r;
			b_op_r   <= (j_r == '0) ? PMME_OP_LOAD : PMME_OP_ADD;
			b_val_r  <= (j_r == '0) ? col_b_r : b_disp_r;
		end
		else
		begin
			iv_r     <= 1'b0;
			ifirst_r <= 1'b0;
			ilast_r  <= 1'b0;
			a_op_r   <= PMME_OP_HOLD;
			b_op_r   <= PMME_OP_HOLD;
		end
	end

	// Entry markers ride along with the data through each stage.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			v1_r     <= 1'b0;
			first1_r <= 1'b0;
			last1_r  <= 1'b0;
			v2_r     <= 1'b0;
			first2_r <= 1'b0;
			last2_r  <= 1'b0;
			rd_en    <= 1'b0;
		end
		else
		begin
			v1_r     <= iv_r;
			first1_r <= ifirst_r;
			last1_r  <= ilast_r;
			rd_en    <= iv_r;
			v2_r     <= v1_r;
			first2_r <= first1_r;
			last2_r  <= last1_r;
		end
	end

	// Product bank address issued two cycles ahead, so it meets the data.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			c_op_r    <= PMME_OP_HOLD;
			c_val_r   <= ADDR_RST;
			c_first_r <= 1'b1;
		end
		else if (st_r == PMME_ST_IDLE && start)
		begin
			c_op_r    <= PMME_OP_HOLD;
			c_first_r <= 1'b1;
		end
		else if (v1_r && last1_r)
		begin
			c_op_r    <= c_first_r ? PMME_OP_LOAD : PMME_OP_ADD;
			c_val_r   <= c_first_r ? c_base_r : c_disp_r;
			c_first_r <= 1'b0;
		end
		else
			c_op_r <= PMME_OP_HOLD;
	end

	////////////////////////////////////////////////////////////////////////
	// Memory read stage ends by capturing both operands.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			op_a_r <= '0;
			op_b_r <= '0;
		end
		else if (v1_r)
		begin
			op_a_r <= rd_data_a;
			op_b_r <= rd_data_b;
		end
	end

	// Multiply-accumulate; the first product of an entry replaces the sum.
	always_comb
	begin
		// Widen both operands first so the full product is never cut.
		prod    = ACC_W'(op_a_r) * ACC_W'(op_b_r);
		acc_nxt = first2_r ? prod : acc_r + prod;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			acc_r <= '0;
		else if (v2_r)
			acc_r <= acc_nxt;
	end

	// Finished sums leave through their own register, freeing the MAC.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wr_data_c <= '0;
			wr_en     <= 1'b0;
		end
		else
		begin
			wr_en <= v2_r && last2_r;
			if (v2_r && last2_r)
				wr_data_c <= acc_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	a_b_col_stride: assert property (@(posedge clk) disable iff (rst)
		(b_op_r == PMME_OP_ADD) |=> rd_addr_b == $past(rd_addr_b) + b_disp_r)
		else $error("Column walk of B did not use its stride.");

	a_write_aligned: assert property (@(posedge clk) disable iff (rst)
		(v2_r && last2_r) |=> wr_en && (wr_addr_c == ag_c.addr) &&
		$past(c_op_r) != PMME_OP_HOLD)
		else $error("Product address and data were not presented together.");

	a_mac_adds: assert property (@(posedge clk) disable iff (rst)
		(v2_r && !first2_r) |=> acc_r == $past(acc_r) + $past(prod))
		else $error("Accumulator did not add the product.");

	a_first_load: assert property (@(posedge clk) disable iff (rst)
		(v2_r && first2_r) |=> acc_r == $past(prod))
		else $error("New entry did not start from its first product.");

	a_out_separate: assert property (@(posedge clk) disable iff (rst)
		wr_en |-> wr_data_c == acc_r)
		else $error("Output register does not hold the finished sum.");

	a_issue_rate: assert property (@(posedge clk) disable iff (rst)
		(st_r == PMME_ST_RUN) |-> ##2 rd_en ##1 v2_r)
		else $error("Pipeline bubble while running.");

	a_loop_nest: assert property (@(posedge clk) disable iff (rst)
		(st_r == PMME_ST_RUN && j_last && !k_last) |=>
		(j_r == '0) && (k_r == $past(k_r) + 16'h0001) && (i_r == $past(i_r)))
		else $error("Inner loop wrap did not advance the middle loop.");

	a_stages_overlap: assert property (@(posedge clk) disable iff (rst)
		(iv_r && v1_r && v2_r) |-> ##1 (v1_r && v2_r && rd_en))
		else $error("Stages did not advance together.");

	a_done_after: assert property (@(posedge clk) disable iff (rst)
		(st_r == PMME_ST_DRAIN && drain_r == 3'h0) |-> ##4 done)
		else $error("Completion not flagged after the pipeline drained.");
endmodule
`default_nettype wire

// ===== testbench/pmme_sram_model.sv
// Three static RAM banks that sit on the far side of the engine.
`timescale 1ns/1ps
`default_nettype none
module pmme_sram_model
import pmme_pkg::*;
#(
	parameter int unsigned DATA_W = 16,
	parameter int unsigned ACC_W  = 40
)
(
	input  wire logic              clk,
	input  wire logic [ADDR_W-1:0] rd_addr_a,
	input  wire logic [ADDR_W-1:0] rd_addr_b,
	input  wire logic              rd_en,
	input  wire logic [ADDR_W-1:0] wr_addr_c,
	input  wire logic [ACC_W-1:0]  wr_data_c,
	input  wire logic              wr_en,
	output var  logic [DATA_W-1:0] rd_data_a,
	output var  logic [DATA_W-1:0] rd_data_b
);
	logic [DATA_W-1:0] mem_a [ADDR_SPACE];
	logic [DATA_W-1:0] mem_b [ADDR_SPACE];
	logic [ACC_W-1:0]  mem_c [ADDR_SPACE];
	logic [DATA_W-1:0] last_a_r;
	logic [DATA_W-1:0] last_b_r;

	////////////////////////////////////////////////////////////////////////
	// Each operand bank answers its own address at once; when not read the
	// lines show the inverse of the last word, so stale data never matches.
	always_comb
	begin
		rd_data_a = rd_en ? mem_a[rd_addr_a] : ~last_a_r;
		rd_data_b = rd_en ? mem_b[rd_addr_b] : ~last_b_r;
	end

	// Remember the last words read to build the released-line pattern.
	always_ff @(posedge clk)
	begin
		if (rd_en)
		begin
			last_a_r <= rd_data_a;
			last_b_r <= rd_data_b;
		end
	end

	// The product bank takes a write in the same cycle as the reads.
	always_ff @(posedge clk)
	begin
		if (wr_en)
			mem_c[wr_addr_c] <= wr_data_c;
	end
endmodule
`default_nettype wire

// ===== testbench/pmme_engine_tb.sv
// Self-checking testbench of the pipelined matrix multiply engine.
`timescale 1ns/1ps
`default_nettype none
module pmme_engine_tb;
	import pmme_pkg::*;

	typedef struct {
		int rows, ca, cb, il;
		logic [15:0] ab, bb, cbase, cd;
		bit full, poke;
	} pmme_row_s;

	// Walk, start while busy, interleaved with single-column rows, wrap at
	// the top of the address space with full-scale data, and empty counts.
	pmme_row_s rows_q [5] = '{
		'{1, 2, 1, 1, 16'h0000, 16'h0100, 16'h0200, 16'h0001, 0, 0},
		'{2, 3, 2, 1, 16'h0010, 16'h0300, 16'h0400, 16'h0001, 0, 1},
		'{3, 1, 3, 2, 16'h0020, 16'h0500, 16'h0600, 16'h0002, 0, 0},
		'{2, 2, 2, 1, 16'hfffe, 16'hfffd, 16'hfffc, 16'h0001, 1, 0},
		'{0, 2, 2, 1, 16'h0040, 16'h0700, 16'h0800, 16'h0001, 0, 0}
	};

	logic clk, rst, start, rd_en, wr_en, busy, done;
	logic [15:0] rc, cac, cbc, a_base, a_disp, a_row_disp, b_base, b_disp;
	logic [15:0] b_col_disp, c_base, c_disp, rd_data_a, rd_data_b;
	logic [15:0] rd_addr_a, rd_addr_b, wr_addr_c;
	logic [39:0] wr_data_c;
	int errors, comparisons, cycles;

	pmme_engine uut (.clk(clk), .rst(rst), .start(start),
		.first_matrix_row_count(rc), .first_matrix_column_count(cac),
		.second_matrix_column_count(cbc), .a_base(a_base),
		.a_disp(a_disp), .a_row_disp(a_row_disp), .b_base(b_base),
		.b_disp(b_disp), .b_col_disp(b_col_disp), .c_base(c_base),
		.c_disp(c_disp), .rd_data_a(rd_data_a), .rd_data_b(rd_data_b),
		.rd_addr_a(rd_addr_a), .rd_addr_b(rd_addr_b), .rd_en(rd_en),
		.wr_addr_c(wr_addr_c), .wr_data_c(wr_data_c), .wr_en(wr_en),
		.busy(busy), .done(done));

	pmme_sram_model mem (.clk(clk), .rd_addr_a(rd_addr_a),
		.rd_addr_b(rd_addr_b), .rd_en(rd_en), .wr_addr_c(wr_addr_c),
		.wr_data_c(wr_data_c), .wr_en(wr_en), .rd_data_a(rd_data_a),
		.rd_data_b(rd_data_b));

	////////////////////////////////////////////////////////////////////////
	// Clock at 250 MHz, and a cycle ceiling well above the longest run.
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			errors++;
			stop_test();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Compare helpers: one for design values, one for bench counts.
	task automatic check_v(input logic [39:0] got, input logic [39:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check_n(input int got, input int exp);
		comparisons++;
		if (got != exp)
		begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic stop_test();
		if (errors == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// One whole multiplication: fill the banks, start, watch every cycle.
	task automatic run(input pmme_row_s r);
		logic [39:0] exp_q [$];
		logic [39:0] acc;
		logic [15:0] ad;
		logic [15:0] bd;
		logic        exp_busy;
		int total, first_rd, first_wr, n_rd, n_wr, done_at, n_done;
		total = r.rows * r.ca * r.cb;
		first_rd = -1;
		first_wr = -1;
		n_rd = 0;
		n_wr = 0;
		n_done = 0;
		done_at = -1;
		for (int i = 0; i < r.rows; i++)
			for (int k = 0; k < r.cb; k++)
			begin
				acc = 40'h0;
				for (int j = 0; j < r.ca; j++)
				begin
					ad = r.ab + 16'((i * r.ca + j) * r.il);
					bd = r.bb + 16'((j * r.cb + k) * r.il);
					mem.mem_a[ad] = r.full ? 16'hffff : ad * 16'h0123 + 16'h0011;
					mem.mem_b[bd] = r.full ? 16'hffff : bd * 16'h0321 + 16'h0007;
					acc += 40'(mem.mem_a[ad]) * 40'(mem.mem_b[bd]);
				end
				exp_q.push_back(acc);
			end
		// The controller hands over every pointer and displacement.
		@(posedge clk);
		rc <= 16'(r.rows);
		cac <= 16'(r.ca);
		cbc <= 16'(r.cb);
		a_base <= r.ab;
		a_disp <= 16'(r.il);
		a_row_disp <= 16'(r.ca * r.il);
		b_base <= r.bb;
		b_disp <= 16'(r.cb * r.il);
		b_col_disp <= 16'(r.il);
		c_base <= r.cbase;
		c_disp <= r.cd;
		start <= 1'b1;
		for (int n = 0; n < total + 12; n++)
		begin
			@(negedge clk);
			if (rd_en === 1'b1)
			begin
				if (first_rd < 0)
					first_rd = n;
				n_rd++;
			end
			if (wr_en === 1'b1)
			begin
				if (first_wr < 0)
					first_wr = n;
				check_v(wr_addr_c, 16'(r.cbase + 16'(n_wr) * r.cd));
				check_v(wr_data_c, exp_q[n_wr % exp_q.size()]);
				n_wr++;
			end
			if (done === 1'b1)
			begin
				done_at = n;
				n_done++;
			end
			// Busy rises the cycle after start and falls with done.
			exp_busy = total > 0 && n >= 1 && n < total + 5;
			check_v(busy, exp_busy);
			@(posedge clk);
			start <= r.poke && n == 3;
		end
		check_n(n_rd, total);
		check_n(n_wr, r.rows * r.cb);
		check_n(n_done, 1);
		check_n(done_at, total == 0 ? 1 : total + 5);
		if (total > 0)
		begin
			check_n(first_rd, 3);
			check_n(first_wr, 3 + r.ca + 1);
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	// Reset, the table of ordinary runs, then a reset in mid-run.
	initial
	begin
		{rst, start, rc, cac, cbc, a_base, a_disp, a_row_disp} = '0;
		{b_base, b_disp, b_col_disp, c_base, c_disp} = '0;
		errors = 0;
		comparisons = 0;
		cycles = 0;
		rst = 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		check_v({rd_en, wr_en, busy, done, rd_addr_a, wr_addr_c}, 40'h0);
		foreach (rows_q[i])
			run(rows_q[i]);
		// A reset while running must clear every strobe at once.
		// The last table row has an empty count, so give real counts here.
		@(posedge clk);
		rc <= 16'h0002;
		cac <= 16'h0002;
		cbc <= 16'h0002;
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		@(negedge clk);
		check_v(busy, 40'h1);
		repeat (4) @(posedge clk);
		rst <= 1'b1;
		@(negedge clk);
		check_v({rd_en, wr_en, busy, done, rd_addr_a, rd_addr_b}, 40'h0);
		@(posedge clk);
		rst <= 1'b0;
		run(rows_q[1]);
		stop_test();
	end
endmodule
`default_nettype wire
